// File: rtl/snid_pkg.sv
// Package of constants for the stack node identifier assignment block
`default_nettype none
package snid_pkg;
   localparam int SNID_ID_W         = 6;
   localparam int SNID_PIN_N        = 6;
   localparam logic [5:0] SNID_ID_RST = 6'h00;
   localparam logic       SNID_SRC_FRAME = 1'b0;
   localparam logic       SNID_SRC_PINS  = 1'b1;
   localparam logic [7:0] SNID_ROLE_BASE = 8'h00;
   localparam logic [7:0] SNID_ROLE_MID  = 8'h02;
   localparam logic [7:0] SNID_ROLE_TOP  = 8'h03;
   typedef enum logic [1:0] {SNID_IDLE, SNID_AUTO, SNID_PIN} snid_state_e;
endpackage
`default_nettype wire

// File: rtl/snid_pin_mux.sv
// Pin identifier gather and pin direction override
`default_nettype none
module snid_pin_mux
   import snid_pkg::*;
#(
   parameter int PIN_N = SNID_PIN_N
) (
   // Pin configuration
   input  wire logic [PIN_N-1:0] pin_id_sel_in,
   input  wire logic [PIN_N-1:0] pin_func_oe_in,
   input  wire logic [PIN_N-1:0] pin_level_in,
   // Results
   output logic [PIN_N-1:0]      pin_oe_out,
   output logic [PIN_N-1:0]      pin_id_out
);
   genvar g;
   generate
      for (g = 0; g < PIN_N; g++) begin : g_pin
         assign pin_oe_out[g] = pin_id_sel_in[g] ? 1'b0 : pin_func_oe_in[g];
         assign pin_id_out[g] = pin_id_sel_in[g] & pin_level_in[g];
      end
   endgenerate
endmodule
`default_nettype wire

// File: rtl/snid_core.sv
// Node identifier assignment core: auto, pin and stored sources
`default_nettype none
// What this block does
// - Source 0 plus arm enters frame mode
// - Upstream transmit off for one frame
// - Next frame with an identifier loads user identifier
// - Arm self-clears after frame, writes blocked
// - New identifier copied to status field
// - Transmit re-enabled when arm clears
// - Each of six pins selectable
// - Pin n drives status bit n
// - Selected pin forced input, function ignored
// - Source 1 plus arm samples pins
// - Unselected pins read as zero
// - Pin mode: arm self-clears, no writes
// - Captured identifier survives pin reconfiguration
// - Reset restores stored identifier from memory
// - Stored identifier writable after assignment
// - Identifier zero accepted
module snid_core
   import snid_pkg::*;
#(
   parameter int ID_W  = SNID_ID_W,
   parameter int PIN_N = SNID_PIN_N
) (
   // Clock and reset
   input  wire logic             clk_sys_in,
   input  wire logic             sys_rst_in,
   // Control
   input  wire logic             id_src_sel_in,
   input  wire logic             arm_set_in,
   input  wire logic [ID_W-1:0]  otp_node_id_in,
   // Frame receive
   input  wire logic             frame_done_in,
   input  wire logic             frame_has_id_in,
   input  wire logic [ID_W-1:0]  frame_id_in,
   // Stored identifier write
   input  wire logic             stored_wr_in,
   input  wire logic [ID_W-1:0]  stored_wr_data_in,
   // Pins
   input  wire logic [PIN_N-1:0] pin_id_sel_in,
   input  wire logic [PIN_N-1:0] pin_func_oe_in,
   input  wire logic [PIN_N-1:0] pin_level_in,
   output logic [PIN_N-1:0]      pin_oe_out,
   // Status
   output logic                  arm_out,
   output logic                  tx_enable_out,
   output logic [ID_W-1:0]       user_node_id_out,
   output logic [ID_W-1:0]       current_node_id_status_out,
   output logic [ID_W-1:0]       stored_node_id_out,
   output logic                  id_updated_out
);
   // Elaboration-time width check: one pin per identifier bit
   generate
      if (ID_W != SNID_ID_W || PIN_N != ID_W) begin : g_bad_width
         $error("snid_core: widths must be 6");
      end
   endgenerate

   snid_state_e        state_reg, state_next;
   logic [ID_W-1:0]    user_reg, status_reg, stored_reg;
   logic               upd_reg, load_done_reg;
   logic [PIN_N-1:0]   pin_id;

   snid_pin_mux #(.PIN_N(PIN_N)) u_mux (
      .pin_id_sel_in (pin_id_sel_in),
      .pin_func_oe_in(pin_func_oe_in),
      .pin_level_in  (pin_level_in),
      .pin_oe_out    (pin_oe_out),
      .pin_id_out    (pin_id)
   );

   wire logic arm_auto  = arm_set_in & (id_src_sel_in == SNID_SRC_FRAME);
   wire logic arm_pin   = arm_set_in & (id_src_sel_in == SNID_SRC_PINS);
   wire logic in_auto   = (state_reg == SNID_AUTO);
   wire logic auto_done = in_auto & frame_done_in;
   wire logic done_any  = auto_done | (state_reg == SNID_PIN);
   wire logic [ID_W-1:0] auto_id = frame_has_id_in ? frame_id_in : user_reg;

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         SNID_IDLE: begin
            if (arm_auto) begin
               state_next = SNID_AUTO;
            end else if (arm_pin) begin
               state_next = SNID_PIN;
            end
         end
         SNID_AUTO: begin
            if (frame_done_in) begin
               state_next = SNID_IDLE;
            end
         end
         SNID_PIN: state_next = SNID_IDLE;
         default:  state_next = SNID_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         state_reg     <= SNID_IDLE;
         user_reg      <= SNID_ID_RST;
         status_reg    <= SNID_ID_RST;
         stored_reg    <= SNID_ID_RST;
         upd_reg       <= 1'b0;
         load_done_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         upd_reg   <= done_any;
         if (!load_done_reg) begin
            stored_reg    <= otp_node_id_in;
            user_reg      <= otp_node_id_in;
            status_reg    <= otp_node_id_in;
            load_done_reg <= 1'b1;
         end else begin
            if (auto_done) begin
               user_reg   <= auto_id;
               status_reg <= auto_id;
            end else if (state_reg == SNID_PIN) begin
               status_reg <= pin_id;
               user_reg   <= pin_id;
            end
            if (stored_wr_in && state_reg == SNID_IDLE) begin
               stored_reg <= stored_wr_data_in;
            end
         end
      end
   end

   assign arm_out                    = (state_reg != SNID_IDLE);
   assign tx_enable_out              = ~in_auto;
   assign user_node_id_out           = user_reg;
   assign current_node_id_status_out = status_reg;
   assign stored_node_id_out         = stored_reg;
   assign id_updated_out             = upd_reg;

   a_tx_off_auto: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      (state_reg == SNID_IDLE && arm_auto && load_done_reg) |=> !tx_enable_out)
      else $error("transmit not disabled in auto mode");
   a_arm_clears: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      auto_done |=> !arm_out && tx_enable_out)
      else $error("arm did not clear after frame");
   a_status_copy: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      (auto_done && load_done_reg) |=> current_node_id_status_out == $past(auto_id))
      else $error("status not updated from frame");
   a_pin_sample: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      (state_reg == SNID_PIN && load_done_reg) |=> current_node_id_status_out == $past(pin_id) && !arm_out)
      else $error("pin identifier not captured");
   a_pin_force_in: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      (pin_oe_out & pin_id_sel_in) == '0)
      else $error("identifier pin driven");
   a_id_hold: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      (state_reg == SNID_IDLE && load_done_reg && $past(load_done_reg)) |=> $stable(current_node_id_status_out))
      else $error("identifier changed without assignment");
   a_tx_back_on: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      (in_auto && frame_done_in) |=> tx_enable_out)
      else $error("transmit not re-enabled");
   a_stored_write: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      (stored_wr_in && state_reg == SNID_IDLE && load_done_reg) |=> stored_node_id_out == $past(stored_wr_data_in))
      else $error("stored identifier write lost");
endmodule
`default_nettype wire

// File: verification/snid_chain_model.sv
// Chain neighbour model that hands received frames to the node
`default_nettype none
module snid_chain_model (
   // Clock and frame request
   input  wire logic       clk_in,
   input  wire logic       send_in,
   input  wire logic [5:0] id_in,
   // Delivered frame
   output logic            done_out = 1'b0,
   output logic [5:0]      id_out = 6'h00
);
   timeunit 1ns;
   timeprecision 1ps;
   always @(posedge clk_in) begin
      done_out <= send_in;
      id_out <= send_in ? id_in : ~id_out;
   end
endmodule
`default_nettype wire

// File: verification/testbench.sv
// Self-checking bench for the node identifier core
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_count++; $display("FAIL %0t mismatch", $time); end end
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic       clk_sys_in = 1'b0, sys_rst_in, id_src_sel_in, arm_set_in, stored_wr_in, send, frame_has_id_in;
   logic       frame_done_in, arm_out, tx_enable_out, id_updated_out;
   logic [5:0] otp_node_id_in, frame_id_in, stored_wr_data_in, pin_id_sel_in, pin_func_oe_in, pin_level_in;
   logic [5:0] pin_oe_out, user_node_id_out, current_node_id_status_out, stored_node_id_out, fid;
   int         err_count, compares;
   snid_core snid_core_inst (.*);
   snid_chain_model snid_chain_model_inst (.clk_in(clk_sys_in), .send_in(send), .id_in(fid),
      .done_out(frame_done_in), .id_out(frame_id_in));
   task automatic step(input int n);
      repeat (n) @(posedge clk_sys_in);
      #1;
   endtask
   task automatic results;
      $display("compares %0d err_count %0d", compares, err_count);
      if (err_count == 0 && compares > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic run(input logic s, h, input logic [5:0] v);
      int i;
      {id_src_sel_in, arm_set_in, frame_has_id_in, fid} = {s, 1'b1, h, v};
      step(1);
      arm_set_in = 1'b0;
      send = !s;
      `CHK(tx_enable_out, s)
      step(1);
      send = 1'b0;
      for (i = 0; i < 20 && arm_out !== 1'b0; i++) step(1);
      `CHK(i < 20, 1'b1)
      if (i == 20) results();
      `CHK(id_updated_out, 1'b1)
      `CHK(tx_enable_out, 1'b1)
   endtask
   initial forever #4 clk_sys_in = ~clk_sys_in;
   initial begin
      sys_rst_in = 1'b1;
      {id_src_sel_in, arm_set_in, stored_wr_in, send, frame_has_id_in, fid, stored_wr_data_in, pin_id_sel_in} = '0;
      {otp_node_id_in, pin_func_oe_in, pin_level_in} = 18'h2AFE7;
      step(12);
      sys_rst_in = 1'b0;
      step(2);
      `CHK(stored_node_id_out, 6'h2A)
      run(1'b0, 1'b1, 6'h05);
      `CHK(user_node_id_out, 6'h05)
      `CHK(current_node_id_status_out, 6'h05)
      run(1'b0, 1'b0, 6'h07);
      `CHK(user_node_id_out, 6'h05)
      run(1'b0, 1'b1, 6'h00);
      `CHK(user_node_id_out, 6'h00)
      stored_wr_in = 1'b1;
      step(1);
      stored_wr_in = 1'b0;
      `CHK(stored_node_id_out, 6'h00)
      $display("test reset and frame mode done");
      for (int n = 0; n < 6; n++) begin
         pin_id_sel_in = 6'h01 << n;
         run(1'b1, 1'b0, 6'h00);
         `CHK(current_node_id_status_out, (6'h01 << n) & 6'h27)
      end
      pin_id_sel_in = 6'h2D;
      run(1'b1, 1'b0, 6'h00);
      `CHK(pin_oe_out, 6'h12)
      `CHK(current_node_id_status_out, 6'h25)
      pin_id_sel_in = 6'h00;
      step(2);
      `CHK(current_node_id_status_out, 6'h25)
      $display("test pin mode done");
      results();
   end
endmodule
`default_nettype wire
